// >>> common/pscl_pkg.sv
// Package: register map, field positions and timing counts for the power and sleep control block
package pscl_pkg;
   // Register word addresses (Avalon word index)
   localparam logic [1:0] ADDR_SLEEP_CTRL = 2'h0;
   localparam logic [1:0] ADDR_CLK_GATE = 2'h1;
   localparam logic [1:0] ADDR_RES_STATUS = 2'h2;
   localparam logic [1:0] ADDR_ENV_CTRL = 2'h3;
   // Control register field positions
   localparam int BIT_BO_REQ = 7;
   localparam int BIT_PULLUP_OFF = 6;
   localparam int BIT_SLEEP_ARM = 5;
   localparam int BIT_SEL_HI = 4;
   localparam int BIT_SEL_LO = 3;
   localparam int BIT_BO_UNLOCK = 2;
   localparam int BIT_SENSE_HI = 1;
   localparam int BIT_SENSE_LO = 0;
   // Clock gate register field positions
   localparam int BIT_GATE_T16 = 3;
   localparam int BIT_GATE_T8 = 2;
   localparam int BIT_GATE_SER = 1;
   localparam int BIT_GATE_CONV = 0;
   localparam logic [7:0] GATE_MASK = 8'h0f;
   // Resource status register field positions
   localparam int ST_CONV_ON = 0;
   localparam int ST_COMP_ON = 1;
   localparam int ST_VREF_ON = 2;
   localparam int ST_BOD_ON = 3;
   localparam int ST_WDT_ON = 4;
   localparam int ST_INBUF_ON = 5;
   localparam int ST_ASLEEP = 6;
   localparam int ST_EXT_CONV = 7;
   // Environment register field positions
   localparam int ENV_CONV_EN = 0;
   localparam int ENV_COMP_EN = 1;
   localparam int ENV_COMP_VREF = 2;
   localparam int ENV_WDT_EN = 3;
   localparam int ENV_BOD_FUSE = 4;
   // Reset values
   localparam logic [7:0] RST_SLEEP_CTRL = 8'h00;
   localparam logic [7:0] RST_CLK_GATE = 8'h00;
   localparam logic [7:0] RST_ENV_CTRL = 8'h00;
   // Timed unlock window, activation delay and request lifetime, in clock cycles
   localparam int UNLOCK_WINDOW_CYC = 4;
   localparam int BO_ACTIVE_DELAY_CYC = 3;
   localparam int BO_LIFE_CYC = 3;
   // Sleep modes
   typedef enum logic [1:0] {
      PSCL_IDLE = 2'b00,
      PSCL_NOISE = 2'b01,
      PSCL_PDOWN = 2'b10,
      PSCL_STBY = 2'b11
   } pscl_mode_t;
endpackage

// >>> common/pscl_bo_if.sv
// Interface: timed brown-out sleep request sequence between top and sequencer
`timescale 1ns/1ps
interface pscl_bo_if;
   logic wr_both;
   logic wr_req_only;
   logic wr_clear;
   logic req_bit;
   logic req_active;
   modport top (output wr_both, output wr_req_only, output wr_clear,
      input req_bit, input req_active);
   modport seq (input wr_both, input wr_req_only, input wr_clear,
      output req_bit, output req_active);
endinterface

// >>> hdl/pscl_bo_seq.sv
// Timed unlock sequencer for the brown-out sleep request
`timescale 1ns/1ps
module pscl_bo_seq #(
   parameter int WINDOW = pscl_pkg::UNLOCK_WINDOW_CYC,
   parameter int DELAY = pscl_pkg::BO_ACTIVE_DELAY_CYC,
   parameter int LIFE = pscl_pkg::BO_LIFE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Sequence carrier
   pscl_bo_if.seq bo
);
   initial begin
      if (WINDOW < 1 || WINDOW > 15 || DELAY < 1 || LIFE < 1 || DELAY + LIFE > 15) begin
         $error("pscl_bo_seq: counts out of range");
      end
   end
   logic [3:0] win_ff;
   logic [3:0] age_ff;
   logic req_ff;
   logic act_ff;

   // Unlock window counter, armed by writing request and unlock together
   always_ff @(posedge clk) begin
      if (rst) begin
         win_ff <= 4'h0;
      end else if (bo.wr_both) begin
         win_ff <= 4'(WINDOW);
      end else if (bo.wr_req_only || bo.wr_clear) begin
         win_ff <= 4'h0;
      end else if (win_ff != 4'h0) begin
         win_ff <= win_ff - 4'h1;
      end
   end

   // Request bit and its age; self-clears after the activation delay plus its lifetime
   always_ff @(posedge clk) begin
      if (rst) begin
         req_ff <= 1'b0;
         age_ff <= 4'h0;
      end else if (bo.wr_req_only && win_ff != 4'h0) begin
         req_ff <= 1'b1;
         age_ff <= 4'h0;
      end else if (req_ff) begin
         age_ff <= age_ff + 4'h1;
         if (age_ff == 4'(DELAY + LIFE - 1)) begin
            req_ff <= 1'b0;
         end
      end
   end

   // Effective after the activation delay, until self-clear
   always_ff @(posedge clk) begin
      if (rst) begin
         act_ff <= 1'b0;
      end else begin
         act_ff <= req_ff && age_ff >= 4'(DELAY - 1) && age_ff < 4'(DELAY + LIFE - 1);
      end
   end

   assign bo.req_bit = req_ff;
   assign bo.req_active = act_ff;
endmodule // pscl_bo_seq

// >>> hdl/pscl_top.sv
// Power and sleep control top: Avalon-MM registers, sleep modes, resource power, clock gates
`timescale 1ns/1ps
// What this block does
// - Enabled converter stays powered in every sleep
// - Converter off-then-on forces extended conversion
// - Comparator off in deep sleep unless reference-linked
// - Reference powered when detector, comparator, converter need
// - Fused brown-out detector stays on unless disabled
// - Enabled watchdog runs in every sleep mode
// - Input buffers off when I/O and converter clocks stop
// - Control register bit layout, read/write, resets zero
// - Request set only by timed two-write sequence
// - Request effective three cycles after set
// - Request self-clears three cycles after it becomes effective
// - Detector off only if sleep during active request
// - Without software disable, request and unlock read zero
// - Sleep entered only while sleep arm is one
// - Select bits choose idle, noise, power-down, standby
// - Unlock bit gates setting of the request
// - Gate register bits 7:4 read zero
// - Bit 3 freezes the 16-bit timer
// - Bit 2 freezes the 8-bit timer
// - Bit 1 stops the serial unit clock
// - Bit 0 shuts the converter, comparator unusable
// - Gated peripheral frozen, its registers inaccessible
module pscl_top #(
   parameter bit HAS_BO_DISABLE = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // CPU sleep handshake
   input wire logic sleep_instr,
   input wire logic wake_event,
   output logic asleep,
   // Pin wake request
   input wire logic pin_wake_async,
   // Peripheral clock enables
   output logic timer16_clk_en,
   output logic timer8_clk_en,
   output logic serial_clk_en,
   output logic conv_clk_en,
   // Resource power
   output logic conv_power,
   output logic comp_power,
   output logic vref_power,
   output logic bod_power,
   output logic wdt_run,
   output logic inbuf_enable,
   output logic conv_extended,
   output logic pullup_global_off,
   output logic [1:0] ext_irq_sense
);
   logic [7:0] ctrl_ff;
   logic [7:0] gate_ff;
   logic [7:0] env_ff;
   logic [31:0] rdata_ff;
   logic wait_ff;
   logic asleep_ff;
   logic bod_off_ff;
   logic ext_conv_ff;
   logic conv_prev_ff;
   logic [1:0] pin_sync_ff;
   logic conv_pw_ff;
   logic comp_pw_ff;
   logic vref_pw_ff;
   logic bod_pw_ff;
   logic wdt_ff;
   logic inbuf_ff;
   logic [3:0] clk_en_ff;
   logic [7:0] status_ff;
   pscl_pkg::pscl_mode_t mode_ff;
   pscl_pkg::pscl_mode_t sel_mode;
   logic acc;
   logic wr_ctrl;
   logic [7:0] wbyte;
   logic conv_on;
   logic comp_on;
   logic bod_on;
   logic deep;
   logic wr_take;
   logic wr_gate;
   logic wr_env;
   logic wake_now;
   logic sleep_go;
   pscl_bo_if bo ();

   // Deep modes stop the I/O and converter clocks
   function automatic logic pscl_is_deep(input pscl_pkg::pscl_mode_t m);
      return (m == pscl_pkg::PSCL_PDOWN) || (m == pscl_pkg::PSCL_STBY);
   endfunction

   // Register word hit for an accepted request
   function automatic logic pscl_hit(input logic take, input logic [1:0] addr,
         input logic [1:0] target);
      return take && (addr == target);
   endfunction

   // Single-cycle wait: request taken on the edge where waitrequest is low
   assign acc = (avs_read || avs_write) && !wait_ff;
   assign wbyte = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
   assign wr_take = acc && avs_write && avs_byteenable[0];
   assign wr_ctrl = pscl_hit(wr_take, avs_address, pscl_pkg::ADDR_SLEEP_CTRL);
   assign wr_gate = pscl_hit(wr_take, avs_address, pscl_pkg::ADDR_CLK_GATE);
   assign wr_env = pscl_hit(wr_take, avs_address, pscl_pkg::ADDR_ENV_CTRL);
   assign sel_mode = pscl_pkg::pscl_mode_t'(ctrl_ff[pscl_pkg::BIT_SEL_HI:pscl_pkg::BIT_SEL_LO]);

   // Sequence strobes toward the request sequencer
   assign bo.wr_both = HAS_BO_DISABLE && wr_ctrl && wbyte[pscl_pkg::BIT_BO_REQ] &&
      wbyte[pscl_pkg::BIT_BO_UNLOCK];
   assign bo.wr_req_only = HAS_BO_DISABLE && wr_ctrl && wbyte[pscl_pkg::BIT_BO_REQ] &&
      !wbyte[pscl_pkg::BIT_BO_UNLOCK];
   assign bo.wr_clear = wr_ctrl && !wbyte[pscl_pkg::BIT_BO_REQ];

   pscl_bo_seq u_seq (
      .clk(clk),
      .rst(rst),
      .bo(bo)
   );

   // Wait state generator
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_ff <= 1'b1;
      end else begin
         wait_ff <= !(avs_read || avs_write) || !wait_ff;
      end
   end

   // Control register; request bit mirrored from sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_ff <= pscl_pkg::RST_SLEEP_CTRL;
      end else if (wr_ctrl) begin
         ctrl_ff[6:3] <= wbyte[6:3];
         ctrl_ff[1:0] <= wbyte[1:0];
         ctrl_ff[pscl_pkg::BIT_BO_UNLOCK] <= HAS_BO_DISABLE &&
            wbyte[pscl_pkg::BIT_BO_UNLOCK];
      end
   end

   // Clock gate register, low nibble only
   always_ff @(posedge clk) begin
      if (rst) begin
         gate_ff <= pscl_pkg::RST_CLK_GATE;
      end else if (wr_gate) begin
         gate_ff <= wbyte & pscl_pkg::GATE_MASK;
      end
   end

   // Environment register: enables and fuse level from elsewhere in the chip
   always_ff @(posedge clk) begin
      if (rst) begin
         env_ff <= pscl_pkg::RST_ENV_CTRL;
      end else if (wr_env) begin
         env_ff <= {3'h0, wbyte[4:0]};
      end
   end

   // Read data staged in the wait cycle so they stand at the taking edge
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read && wait_ff) begin
         unique case (avs_address)
            pscl_pkg::ADDR_SLEEP_CTRL:
               rdata_ff <= {24'h0, HAS_BO_DISABLE && bo.req_bit, ctrl_ff[6:0]};
            pscl_pkg::ADDR_CLK_GATE: rdata_ff <= {24'h0, gate_ff};
            pscl_pkg::ADDR_RES_STATUS: rdata_ff <= {24'h0, status_ff};
            pscl_pkg::ADDR_ENV_CTRL: rdata_ff <= {24'h0, env_ff};
         endcase
      end
   end

   // Wake pin synchroniser
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_sync_ff <= 2'b00;
      end else begin
         pin_sync_ff <= {pin_sync_ff[0], pin_wake_async};
      end
   end

   // Wake sources and armed sleep request
   assign wake_now = wake_event || pin_sync_ff[1];
   assign sleep_go = sleep_instr && ctrl_ff[pscl_pkg::BIT_SLEEP_ARM];

   // Sleep state; a wake only leaves sleep, a sleep request while awake enters even with a wake in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         asleep_ff <= 1'b0;
      end else if (asleep_ff) begin
         if (wake_now) begin
            asleep_ff <= 1'b0;
         end
      end else if (sleep_go) begin
         asleep_ff <= 1'b1;
      end
   end

   // Mode latched at entry, held through the sleep period
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_ff <= pscl_pkg::PSCL_IDLE;
      end else if (!asleep_ff && sleep_go) begin
         mode_ff <= sel_mode;
      end
   end

   // Detector disable latched at entry to power-down or standby while the request is active, dropped at wake
   always_ff @(posedge clk) begin
      if (rst) begin
         bod_off_ff <= 1'b0;
      end else if (asleep_ff) begin
         if (wake_now) begin
            bod_off_ff <= 1'b0;
         end
      end else if (sleep_go) begin
         bod_off_ff <= bo.req_active && pscl_is_deep(sel_mode);
      end
   end

   // Resource power decisions
   assign conv_on = env_ff[pscl_pkg::ENV_CONV_EN] && !gate_ff[pscl_pkg::BIT_GATE_CONV];
   assign deep = asleep_ff && pscl_is_deep(mode_ff);
   assign comp_on = env_ff[pscl_pkg::ENV_COMP_EN] && !gate_ff[pscl_pkg::BIT_GATE_CONV] &&
      (!deep || env_ff[pscl_pkg::ENV_COMP_VREF]);
   assign bod_on = env_ff[pscl_pkg::ENV_BOD_FUSE] && !bod_off_ff;

   // Converter power follows its enable in every sleep mode
   always_ff @(posedge clk) begin
      if (rst) begin
         conv_pw_ff <= 1'b0;
      end else begin
         conv_pw_ff <= conv_on;
      end
   end

   // Comparator power, dropped in deep sleep unless reference-linked
   always_ff @(posedge clk) begin
      if (rst) begin
         comp_pw_ff <= 1'b0;
      end else begin
         comp_pw_ff <= comp_on;
      end
   end

   // Reference power while any user needs it
   always_ff @(posedge clk) begin
      if (rst) begin
         vref_pw_ff <= 1'b0;
      end else begin
         vref_pw_ff <= bod_on || conv_on ||
            (comp_on && env_ff[pscl_pkg::ENV_COMP_VREF]);
      end
   end

   // Detector power; with the fuse set, off only for a software-disabled sleep
   always_ff @(posedge clk) begin
      if (rst) begin
         bod_pw_ff <= 1'b0;
      end else begin
         bod_pw_ff <= bod_on;
      end
   end

   // Watchdog run follows its enable, never the sleep mode
   always_ff @(posedge clk) begin
      if (rst) begin
         wdt_ff <= 1'b0;
      end else begin
         wdt_ff <= env_ff[pscl_pkg::ENV_WDT_EN];
      end
   end

   // Input buffers off while I/O and converter clocks stop
   always_ff @(posedge clk) begin
      if (rst) begin
         inbuf_ff <= 1'b0;
      end else begin
         inbuf_ff <= !deep;
      end
   end

   // Extended conversion flag after converter power cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         conv_prev_ff <= 1'b0;
         ext_conv_ff <= 1'b1;
      end else begin
         conv_prev_ff <= conv_on;
         if (conv_on && !conv_prev_ff) begin
            ext_conv_ff <= 1'b1;
         end else if (env_ff[pscl_pkg::ENV_COMP_VREF + 5] == 1'b0 && conv_on &&
               acc && avs_read && avs_address == pscl_pkg::ADDR_RES_STATUS) begin
            ext_conv_ff <= 1'b0; // Acknowledged by a status read
         end
      end
   end

   // Peripheral clock enables; a gated peripheral freezes with its registers
   always_ff @(posedge clk) begin
      if (rst) begin
         clk_en_ff <= 4'hf;
      end else begin
         clk_en_ff[pscl_pkg::BIT_GATE_T16] <= !gate_ff[pscl_pkg::BIT_GATE_T16];
         clk_en_ff[pscl_pkg::BIT_GATE_T8] <= !gate_ff[pscl_pkg::BIT_GATE_T8];
         clk_en_ff[pscl_pkg::BIT_GATE_SER] <= !gate_ff[pscl_pkg::BIT_GATE_SER];
         clk_en_ff[pscl_pkg::BIT_GATE_CONV] <= !gate_ff[pscl_pkg::BIT_GATE_CONV];
      end
   end

   // Status snapshot
   always_ff @(posedge clk) begin
      if (rst) begin
         status_ff <= 8'h00;
      end else begin
         status_ff <= {ext_conv_ff, asleep_ff, inbuf_ff, wdt_ff, bod_pw_ff, vref_pw_ff,
            comp_pw_ff, conv_pw_ff};
      end
   end

   // Output drive
   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign asleep = asleep_ff;
   assign timer16_clk_en = clk_en_ff[pscl_pkg::BIT_GATE_T16];
   assign timer8_clk_en = clk_en_ff[pscl_pkg::BIT_GATE_T8];
   assign serial_clk_en = clk_en_ff[pscl_pkg::BIT_GATE_SER];
   assign conv_clk_en = clk_en_ff[pscl_pkg::BIT_GATE_CONV];
   assign conv_power = conv_pw_ff;
   assign comp_power = comp_pw_ff;
   assign vref_power = vref_pw_ff;
   assign bod_power = bod_pw_ff;
   assign wdt_run = wdt_ff;
   assign inbuf_enable = inbuf_ff;
   assign conv_extended = ext_conv_ff;
   assign pullup_global_off = ctrl_ff[pscl_pkg::BIT_PULLUP_OFF];
   assign ext_irq_sense = ctrl_ff[pscl_pkg::BIT_SENSE_HI:pscl_pkg::BIT_SENSE_LO];
endmodule // pscl_top

// >>> sim/pscl_top_checker.sv
// Checker: concurrent assertions on the power and sleep control top ports
`timescale 1ns/1ps
module pscl_top_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire logic [1:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   // Sleep handshake
   input wire logic sleep_instr,
   input wire logic wake_event,
   input wire logic asleep,
   // Clock enables and power
   input wire logic timer16_clk_en,
   input wire logic timer8_clk_en,
   input wire logic serial_clk_en,
   input wire logic conv_clk_en,
   input wire logic conv_power,
   input wire logic comp_power,
   input wire logic vref_power,
   input wire logic bod_power,
   input wire logic wdt_run,
   input wire logic pullup_global_off,
   input wire logic [1:0] ext_irq_sense
);
   logic [7:0] ctrl_ff, gate_ff, env_ff;
   logic [1:0] quiet_ff;
   logic wr_take, settled;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Accepted write and quiet time since it
   assign wr_take = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign settled = (quiet_ff == 2'h3);
   // Shadow copies of the written registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_ff <= 8'h00;
         gate_ff <= 8'h00;
         env_ff <= 8'h00;
         quiet_ff <= 2'h0;
      end else if (wr_take) begin
         quiet_ff <= 2'h0;
         if (avs_address == pscl_pkg::ADDR_SLEEP_CTRL) ctrl_ff <= avs_writedata[7:0];
         if (avs_address == pscl_pkg::ADDR_CLK_GATE) gate_ff <= avs_writedata[7:0];
         if (avs_address == pscl_pkg::ADDR_ENV_CTRL) env_ff <= avs_writedata[7:0];
      end else if (!settled) begin
         quiet_ff <= quiet_ff + 2'h1;
      end
   end
   a_t16_gate: assert property (settled |-> timer16_clk_en == !gate_ff[3])
      else $error("timer16 enable wrong");
   a_t8_gate: assert property (settled |-> timer8_clk_en == !gate_ff[2])
      else $error("timer8 enable wrong");
   a_serial_gate: assert property (settled |-> serial_clk_en == !gate_ff[1])
      else $error("serial enable wrong");
   a_conv_gate: assert property (settled |-> conv_clk_en == !gate_ff[0])
      else $error("converter enable wrong");
   a_arm_enter: assert property (!asleep && sleep_instr && ctrl_ff[5] && !wake_event |=> asleep)
      else $error("armed sleep not entered");
   a_arm_block: assert property (!asleep && !ctrl_ff[5] |=> !asleep)
      else $error("sleep entered unarmed");
   a_direct_bits: assert property ({pullup_global_off, ext_irq_sense} == {ctrl_ff[6], ctrl_ff[1:0]})
      else $error("control bits not on pins");
   a_conv_kept: assert property (settled && env_ff[0] && !gate_ff[0] |-> conv_power)
      else $error("enabled converter unpowered");
   a_comp_deep: assert property (settled && asleep && $past(asleep) && ctrl_ff[4] && !env_ff[2]
      |-> !comp_power)
      else $error("comparator on in deep sleep");
   a_vref_need: assert property (settled && !asleep && !$past(asleep) && !gate_ff[0]
      |-> vref_power == (env_ff[4] || env_ff[0] || (env_ff[1] && env_ff[2])))
      else $error("reference power wrong");
   a_bod_fused: assert property (settled && env_ff[4] && ((!asleep && !$past(asleep)) || !ctrl_ff[4])
      |-> bod_power)
      else $error("fused detector off");
   a_wdt_runs: assert property (settled && env_ff[3] |-> wdt_run)
      else $error("watchdog stopped");
   // Main scenarios reached
   c_sleep: cover property ($rose(asleep));
   c_bod_off: cover property (asleep && !bod_power);
   c_gated: cover property (!timer16_clk_en);
endmodule // pscl_top_checker

bind pscl_top pscl_top_checker u_chk (.clk, .rst, .avs_address, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_waitrequest, .sleep_instr, .wake_event, .asleep, .timer16_clk_en,
   .timer8_clk_en, .serial_clk_en, .conv_clk_en, .conv_power, .comp_power, .vref_power,
   .bod_power, .wdt_run, .pullup_global_off, .ext_irq_sense);

// >>> sim/pscl_top_tb.sv
// Testbench: register, sleep and gating sequences for the power and sleep control top
`timescale 1ns/1ps
module pscl_top_tb;
   logic clk, rst, avs_read, avs_write, avs_waitrequest, sleep_instr, wake_event, asleep;
   logic [1:0] avs_address, ext_irq_sense;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] clk_en;
   logic conv_power, comp_power, vref_power, bod_power, wdt_run, conv_extended, pullup_global_off;
   logic inbuf_enable;
   logic [7:0] rdv;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   // Device under test
   pscl_top DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sleep_instr(sleep_instr), .wake_event(wake_event), .asleep(asleep),
      .pin_wake_async(1'b0), .timer16_clk_en(clk_en[3]), .timer8_clk_en(clk_en[2]),
      .serial_clk_en(clk_en[1]), .conv_clk_en(clk_en[0]), .conv_power(conv_power),
      .comp_power(comp_power), .vref_power(vref_power), .bod_power(bod_power),
      .wdt_run(wdt_run), .inbuf_enable(inbuf_enable), .conv_extended(conv_extended),
      .pullup_global_off(pullup_global_off), .ext_irq_sense(ext_irq_sense));
   // Clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   // Read data are taken at the edge where waitrequest is seen low
   task automatic rd(input logic [1:0] a);
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rdv = avs_readdata[7:0];
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   // One sleep and wake round with the power outputs seen while asleep
   task automatic doze(input logic exp_sl, input logic [7:0] exp_pw);
      sleep_instr <= 1'b1;
      @(posedge clk);
      sleep_instr <= 1'b0;
      repeat (3) @(posedge clk);
      chk("asleep", {7'h0, exp_sl}, {7'h0, asleep});
      chk("power", exp_pw, {2'h0, vref_power, inbuf_enable, conv_power, comp_power, bod_power,
         wdt_run});
      wake_event <= 1'b1;
      @(posedge clk);
      wake_event <= 1'b0;
      repeat (3) @(posedge clk);
      chk("awake", 8'h01, {7'h0, !asleep});
   endtask
   initial begin
      rst = 1'b1;
      {avs_read, avs_write, sleep_instr, wake_event} = 4'h0;
      avs_address = 2'h0;
      avs_writedata = 32'h0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("clk_en", 8'h0f, {4'h0, clk_en});
      rd(pscl_pkg::ADDR_SLEEP_CTRL);
      chk("ctrl", 8'h00, rdv);
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'h7b);
      rd(pscl_pkg::ADDR_SLEEP_CTRL);
      chk("ctrl", 8'h7b, rdv);
      chk("pins", 8'h07, {5'h0, pullup_global_off, ext_irq_sense});
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'h04);
      rd(pscl_pkg::ADDR_SLEEP_CTRL);
      chk("unlock", 8'h04, rdv);
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'h80);
      rd(pscl_pkg::ADDR_SLEEP_CTRL);
      chk("lone_req", 8'h00, rdv);
      // Second write too late
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'h84);
      repeat (5) @(posedge clk);
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'h80);
      rd(pscl_pkg::ADDR_SLEEP_CTRL);
      chk("late_req", 8'h00, rdv);
      // Valid sequence, then self clear
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'h84);
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'h80);
      rd(pscl_pkg::ADDR_SLEEP_CTRL);
      chk("req_set", 8'h80, rdv);
      repeat (4) @(posedge clk);
      rd(pscl_pkg::ADDR_SLEEP_CTRL);
      chk("req_clear", 8'h00, rdv);
      // Each gate bit stops only its own clock
      for (int i = 0; i < 4; i++) begin
         wr(pscl_pkg::ADDR_CLK_GATE, 8'h01 << i);
         repeat (2) @(posedge clk);
         chk("clk_en", ~(8'h01 << i) & 8'h0f, {4'h0, clk_en});
      end
      wr(pscl_pkg::ADDR_CLK_GATE, 8'hff);
      rd(pscl_pkg::ADDR_CLK_GATE);
      chk("gate_rsv", 8'h0f, rdv);
      wr(pscl_pkg::ADDR_CLK_GATE, 8'h00);
      // Every sleep mode with converter, comparator, watchdog and fused detector on
      wr(pscl_pkg::ADDR_ENV_CTRL, 8'h1b);
      for (int m = 0; m < 4; m++) begin
         wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'(8'h20 | (m << 3)));
         doze(1'b1, (m < 2) ? 8'h3f : 8'h2b);
      end
      wr(pscl_pkg::ADDR_ENV_CTRL, 8'h1f);
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'h30);
      doze(1'b1, 8'h2f);
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'h10);
      doze(1'b0, 8'h3f);
      // Sleep before the request is active keeps the detector
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'hb4);
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'hb0);
      doze(1'b1, 8'h2f);
      // Sleep inside the active window drops the detector until wake
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'hb4);
      wr(pscl_pkg::ADDR_SLEEP_CTRL, 8'hb0);
      repeat (2) @(posedge clk);
      doze(1'b1, 8'h2d);
      chk("bod_back", 8'h01, {7'h0, bod_power});
      // Converter off then on forces an extended conversion
      wr(pscl_pkg::ADDR_ENV_CTRL, 8'h01);
      rd(pscl_pkg::ADDR_RES_STATUS);
      repeat (2) @(posedge clk);
      chk("ext_conv", 8'h00, {7'h0, conv_extended});
      wr(pscl_pkg::ADDR_ENV_CTRL, 8'h00);
      wr(pscl_pkg::ADDR_ENV_CTRL, 8'h01);
      repeat (2) @(posedge clk);
      chk("ext_conv", 8'h01, {7'h0, conv_extended});
      tally_and_finish();
   end
endmodule // pscl_top_tb
